// ===== hw/trace_power_sync_pkg.sv
package trace_power_sync_pkg;

  typedef enum logic [1:0] {
    pwr_normal    = 2'b00,
    pwr_standby   = 2'b01,
    pwr_retention = 2'b10,
    pwr_powerdown = 2'b11
  } power_state_type;

  typedef enum logic [1:0] {
    sync_idle  = 2'b00,
    sync_drain = 2'b01,
    sync_flush = 2'b10
  } sync_state_type;

  localparam logic [11:0] addr_power_down_status = 12'h000;
  localparam logic [11:0] addr_control           = 12'h004;
  localparam logic [11:0] addr_status            = 12'h008;

  localparam int control_enable_bit     = 0;
  localparam int control_buffer_en_bit  = 1;
  localparam int control_ext_out_lsb    = 4;
  localparam int ext_out_width          = 4;
  localparam int pdsr_sticky_bit        = 1;
  localparam int pdsr_power_bit         = 0;

  localparam int status_sync_busy_bit   = 0;
  localparam int status_quiesced_bit    = 1;
  localparam int status_low_power_bit   = 2;
  localparam int status_pending_lsb     = 4;

  localparam logic [7:0] control_reset  = 8'h00;
  localparam logic       sticky_reset   = 1'b1;

  localparam logic [7:0] header_instr     = 8'h10;
  localparam logic [7:0] header_exception = 8'h20;

  localparam int pending_width = 4;
  localparam logic [3:0] pending_max = 4'hE;

endpackage

// ===== hw/trace_packet_if.sv
interface trace_packet_if;
  logic       start;
  logic       exception;
  logic [7:0] payload;
  logic       busy;

  modport source (output start, output exception, output payload,
                  input busy);
  modport sink   (input start, input exception, input payload,
                  output busy);
endinterface

// ===== hw/trace_packet_emitter.sv
module trace_packet_emitter
  import trace_power_sync_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  trace_packet_if.sink    pkt,
  input  wire logic       trace_ready,
  output logic [7:0]      trace_data,
  output logic            trace_valid,
  output logic            trace_last
);

  logic       second;
  logic [7:0] held_payload;

  // Two-byte packet; the last flag always marks the closing byte
  always_ff @(posedge clk) begin
    if (rst) begin
      trace_valid  <= 1'b0;
      trace_data   <= 8'h00;
      trace_last   <= 1'b0;
      second       <= 1'b0;
      held_payload <= 8'h00;
    end else if (trace_valid && !trace_ready) begin
      trace_valid <= 1'b1;
    end else if (second) begin
      trace_valid <= 1'b1;
      trace_data  <= held_payload;
      trace_last  <= 1'b1;
      second      <= 1'b0;
    end else if (pkt.start) begin
      trace_valid  <= 1'b1;
      trace_data   <= pkt.exception ? header_exception : header_instr;
      trace_last   <= 1'b0;
      second       <= 1'b1;
      held_payload <= pkt.payload;
    end else begin
      trace_valid <= 1'b0;
      trace_last  <= 1'b0;
    end
  end

  // Busy until the closing byte has been accepted downstream; start is
  // left out, since the start itself is gated by busy
  assign pkt.busy = second || trace_valid;

endmodule

// ===== hw/trace_power_sync_control.sv
// Function
// R1: Standby keeps registers and bus behaviour exactly as in normal operation.
// R2: Retention blocks register access; leaving it does not reset the unit.
// R3: Powerdown blocks register access; leaving it resets the trace unit.
// R4: A powered-down processing element forces this domain powered down too.
// R5: Status reads sticky flag and power bit; sticky one means state lost.
// R6: Retained power-down restores the sticky flag to its earlier value.
// R7: Non-retained power-down sets the sticky flag to one.
// R8: The power bit always reads one; the code reads zero in retention and powerdown.
// R9: Indirect reads follow context sync and barrier ordering.
// R10: Every instruction outside prohibited regions is observed.
// R11: Every exceptional occurrence outside prohibited regions is observed.
// R12: All execution before a context sync is observed before it.
// R13: A barrier instruction raises a trace synchronization event.
// R14: Barrier in prohibited region waits until generation is paused or idle.
// R15: Outside transactions, barrier finishes after earlier trace completes.
// R16: Inside a transaction the sync event completes in bounded time.
// R17: Sync completion never waits for transaction commit or fail.
// R18: After a prohibited-region barrier finishes, no trace until region exit.
// R19: Flushed output ends on a complete packet's last byte.
// R20: Enabled inside a prohibited region, no trace until region exit.
// R21: With buffer enabled, sync completes after stream flushed into buffer.
// R22: In the low-power state outputs stay low and no trace is made.
// R23: Power controller supplies encoded power state and retained flag.
module trace_power_sync_control
  import trace_power_sync_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          hsel,
  input  wire logic [11:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic [31:0]                        hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire trace_power_sync_pkg::power_state_type power_state,
  input  wire logic                          regs_retained,
  input  wire logic                          pe_powered_down,
  input  wire logic                          instr_retired,
  input  wire logic                          exception_taken,
  input  wire logic                          in_prohibited,
  input  wire logic                          in_transaction,
  input  wire logic                          context_sync,
  input  wire logic                          trace_sync_barrier_instr,
  output logic                               sync_done,
  output logic                               pe_stall,
  input  wire logic                          trace_ready,
  output logic [7:0]                         trace_data,
  output logic                               trace_valid,
  output logic                               trace_last,
  output logic [trace_power_sync_pkg::ext_out_width-1:0] ext_out
);

  trace_packet_if pkt ();

  power_state_type             effective_state;
  power_state_type             prev_state;
  logic                        domain_down;
  logic                        was_down;
  logic                        leave_down;
  logic                        unit_reset;
  logic                        low_power;
  logic                        sticky_powerdown_flag;
  logic                        sticky_saved;
  logic [7:0]                  control;
  logic                        enable_prev;
  logic                        quiesced;
  logic [pending_width-1:0]    pending;
  logic [pending_width-1:0]    next_pending;
  logic [7:0]                  seq;
  logic                        gen_allowed;
  logic                        observe_instr;
  logic                        observe_exc;
  logic                        issue;
  logic                        issue_exc;
  sync_state_type              sync_state;
  logic                        sync_prohibited;
  logic                        data_phase;
  logic                        data_write;
  logic [11:0]                 data_addr;
  logic                        addr_valid;
  logic                        pdsr_read;
  logic                        regs_open;

  function automatic logic is_down(input power_state_type s);
    is_down = (s == pwr_retention) || (s == pwr_powerdown);
  endfunction

  // The core cannot be down while this domain claims to be up
  assign effective_state = pe_powered_down ? pwr_powerdown
                                           : power_state; // R4
  assign domain_down = is_down(effective_state);
  assign was_down    = is_down(prev_state);
  assign leave_down  = was_down && !domain_down;
  // Only a powerdown exit resets; retention keeps everything
  assign unit_reset  = rst ||
                       (leave_down && prev_state == pwr_powerdown); // R3
  assign low_power   = (effective_state == pwr_standby);
  assign regs_open   = !domain_down; // R1 R2 R3

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_state <= pwr_normal;
    end else begin
      prev_state <= effective_state;
    end
  end

  // Bus slave: zero wait states, always OKAY
  // IDLE and BUSY transfers are ignored; only NONSEQ or SEQ is taken
  assign addr_valid = hsel && htrans[1] && hready;

  always_ff @(posedge clk) begin
    if (rst) begin
      data_phase <= 1'b0;
      data_write <= 1'b0;
      data_addr  <= 12'h000;
    end else begin
      data_phase <= addr_valid;
      data_write <= addr_valid && hwrite;
      data_addr  <= haddr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data is prepared in the address phase so it stands registered
  // throughout the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_valid && !hwrite && regs_open) begin
      case (haddr)
        addr_power_down_status: begin
          hrdata <= 32'h0000_0000;
          hrdata[pdsr_sticky_bit] <= sticky_powerdown_flag; // R5
          hrdata[pdsr_power_bit]  <= 1'b1; // R8
        end
        addr_control: begin
          hrdata <= {24'h00_0000, control};
        end
        addr_status: begin
          hrdata <= 32'h0000_0000;
          hrdata[status_sync_busy_bit] <= (sync_state != sync_idle);
          hrdata[status_quiesced_bit]  <= quiesced;
          hrdata[status_low_power_bit] <= low_power;
          hrdata[status_pending_lsb +: pending_width] <= pending;
        end
        default: begin
          hrdata <= 32'h0000_0000;
        end
      endcase
    end else if (addr_valid) begin
      // Powered-down domain: reads return zero, nothing is touched
      hrdata <= 32'h0000_0000; // R2 R3
    end
  end

  assign pdsr_read = addr_valid && !hwrite && regs_open &&
                     haddr == addr_power_down_status;

  always_ff @(posedge clk) begin
    if (unit_reset) begin
      control <= control_reset;
    end else if (data_phase && data_write && regs_open &&
                 data_addr == addr_control) begin
      control <= hwdata[7:0];
    end
  end

  // Sticky flag: a read clears it; a power event in the same cycle wins
  // Entering a down state saves the flag for a retained wake-up
  always_ff @(posedge clk) begin
    if (rst) begin
      sticky_powerdown_flag <= sticky_reset;
      sticky_saved          <= sticky_reset;
    end else if (domain_down && !was_down) begin
      sticky_saved <= sticky_powerdown_flag;
    end else if (leave_down) begin
      if (regs_retained) begin
        sticky_powerdown_flag <= sticky_saved; // R6
      end else begin
        sticky_powerdown_flag <= 1'b1; // R7
      end
    end else if (pdsr_read) begin
      sticky_powerdown_flag <= 1'b0;
    end
  end

  // Quiesce after a prohibited-region barrier finishes, or on enabling
  // inside a region; leaving the region or a powerdown-exit reset lifts it
  always_ff @(posedge clk) begin
    if (unit_reset) begin
      enable_prev <= 1'b0;
      quiesced    <= 1'b0;
    end else begin
      enable_prev <= control[control_enable_bit];
      if (!in_prohibited) begin
        quiesced <= 1'b0; // R18 R20
      end else if (control[control_enable_bit] && !enable_prev) begin
        quiesced <= 1'b1; // R20
      end else if (sync_state == sync_flush && sync_prohibited &&
                   !pkt.busy) begin
        quiesced <= 1'b1; // R18
      end
    end
  end

  // The region input gates trace itself; quiesced only reports, because
  // it lags the region exit by a cycle and would drop that instruction
  assign gen_allowed = control[control_enable_bit] && !in_prohibited &&
                       !low_power && regs_open; // R18 R20 R22
  assign observe_instr = instr_retired && gen_allowed; // R10
  assign observe_exc   = exception_taken && gen_allowed; // R11

  // Events wait here until the emitter can take them, so a context sync
  // or barrier always sees everything older in the count
  // Held events wait out low power and retention instead of leaking; a powerdown exit drops them
  assign issue = (pending != '0) && !pkt.busy &&
                 !low_power && regs_open; // R22

  always_comb begin
    next_pending = pending;
    if (observe_instr || observe_exc) begin
      next_pending = next_pending + 4'h1; // R12
    end
    if (issue) begin
      next_pending = next_pending - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (unit_reset) begin
      pending   <= '0;
      issue_exc <= 1'b0;
    end else begin
      pending <= next_pending; // R9
      if (observe_exc) begin
        issue_exc <= 1'b1;
      end else if (issue) begin
        issue_exc <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (unit_reset) begin
      seq <= 8'h00;
    end else if (issue) begin
      seq <= seq + 8'h01;
    end
  end

  assign pkt.start     = issue;
  assign pkt.exception = issue_exc;
  assign pkt.payload   = seq;

  // Back-pressure keeps the event count from overflowing
  // A context sync stalls the core, for as long as it stays asserted, until every older event has issued
  always_ff @(posedge clk) begin
    if (unit_reset) begin
      pe_stall <= 1'b0;
    end else begin
      pe_stall <= (next_pending >= pending_max) ||
                  (context_sync && next_pending != '0); // R12
    end
  end

  // Barrier sequencing. Completion depends only on the drain of earlier
  // trace, never on transaction outcome, so the wait is bounded by the
  // pending count times the packet length plus downstream stall
  always_ff @(posedge clk) begin
    if (unit_reset) begin
      sync_state      <= sync_idle;
      sync_prohibited <= 1'b0;
      sync_done       <= 1'b0;
    end else begin
      sync_done <= 1'b0;
      case (sync_state)
        sync_idle: begin
          if (trace_sync_barrier_instr) begin
            sync_state      <= sync_drain; // R13
            sync_prohibited <= in_prohibited;
          end
        end
        sync_drain: begin
          // Generation is already paused inside a region, so only the
          // older events remain to drain
          if (pending == '0 && !(observe_instr || observe_exc)) begin
            sync_state <= sync_flush; // R14 R15 R16 R17
          end
        end
        sync_flush: begin
          // Emitter idle means the last byte sent closed a packet and,
          // when buffered, every byte has been accepted
          if (!pkt.busy || !control[control_buffer_en_bit]) begin
            if (!pkt.busy) begin
              sync_state <= sync_idle; // R19 R21
              sync_done  <= 1'b1;
            end
          end
        end
        default: begin
          sync_state <= sync_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (unit_reset) begin
      ext_out <= '0;
    end else if (low_power || domain_down) begin
      ext_out <= '0; // R22
    end else begin
      ext_out <= control[control_ext_out_lsb +: ext_out_width]; // R1
    end
  end

  // The emitter shares the power-down reset so no half packet survives
  trace_packet_emitter emitter (
    .clk         (clk),
    .rst         (unit_reset),
    .pkt         (pkt),
    .trace_ready (trace_ready),
    .trace_data  (trace_data),
    .trace_valid (trace_valid),
    .trace_last  (trace_last)
  );

endmodule

// ===== tb/trace_power_sync_control_checker.sv
module trace_power_sync_control_checker
  import trace_power_sync_pkg::*;
(
  input wire logic                              clk,
  input wire logic                              rst,
  input wire logic                              hreadyout,
  input wire logic                              hresp,
  input wire trace_power_sync_pkg::power_state_type power_state,
  input wire logic                              in_prohibited,
  input wire logic                              trace_sync_barrier_instr,
  input wire logic                              sync_done,
  input wire logic                              trace_ready,
  input wire logic [7:0]                        trace_data,
  input wire logic                              trace_valid,
  input wire logic                              trace_last,
  input wire logic [trace_power_sync_pkg::ext_out_width-1:0] ext_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Set once a barrier finishes inside a prohibited region
  logic quiet;
  always_ff @(posedge clk) begin
    if (rst || !in_prohibited)
      quiet <= 1'b0;
    else if (sync_done)
      quiet <= 1'b1;
  end

  a_ext_low_power: assert property (power_state != pwr_normal &&
    $past(power_state) != pwr_normal |-> ext_out == '0)
    else $error("external outputs not low in low power");
  a_no_new_trace: assert property (power_state != pwr_normal &&
    $past(power_state) != pwr_normal && !$past(trace_valid) |-> !trace_valid)
    else $error("trace started in low power");
  a_quiet_region: assert property (quiet |-> !trace_valid)
    else $error("trace after barrier in prohibited region");
  a_done_one_cycle: assert property (sync_done |=> !sync_done)
    else $error("sync done longer than one cycle");
  a_done_flushed: assert property (sync_done |-> !trace_valid)
    else $error("sync done with bytes still pending");
  a_packet_closes: assert property (trace_valid && trace_ready &&
    !trace_last |=> trace_valid && trace_last)
    else $error("packet not closed by second byte");
  a_stall_holds: assert property (trace_valid && !trace_ready |=>
    trace_valid && $stable(trace_data) && $stable(trace_last))
    else $error("byte changed while buffer stalled");
  a_header_code: assert property (trace_valid && !trace_last |->
    trace_data == header_instr || trace_data == header_exception)
    else $error("bad packet header");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_sync_bounded: assert property (trace_sync_barrier_instr |->
    ##[1:400] sync_done)
    else $error("sync did not complete in time");

  cover property (sync_done && in_prohibited);
  cover property (trace_valid && trace_ready && trace_last);
  cover property (trace_valid && !trace_ready);
endmodule

bind trace_power_sync_control trace_power_sync_control_checker checker_inst (
  .clk, .rst, .hreadyout, .hresp, .power_state, .in_prohibited,
  .trace_sync_barrier_instr, .sync_done, .trace_ready, .trace_data,
  .trace_valid, .trace_last, .ext_out
);

// ===== tb/trace_buffer_model.sv
module trace_buffer_model (
  input wire logic  clk,
  input wire logic  rst,
  input wire logic  stall_en,
  input wire logic  trace_valid,
  input wire logic  trace_last,
  output logic      trace_ready = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  int byte_count = 0;
  int pkt_count = 0;

  // Random back-pressure exercises the hold path of the stream
  always @(posedge clk) begin
    trace_ready <= stall_en ? 1'($urandom % 2) : 1'b1;
    if (!rst && trace_valid && trace_ready) begin
      byte_count <= byte_count + 1;
      if (trace_last)
        pkt_count <= pkt_count + 1;
    end
  end
endmodule

// ===== tb/trace_power_sync_control_bench.sv
module trace_power_sync_control_bench
  import trace_power_sync_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            hsel = 1'b0;
  logic [11:0]     haddr = '0;
  logic [1:0]      htrans = '0;
  logic            hwrite = 1'b0;
  logic [2:0]      hsize = 3'b010;
  logic [31:0]     hwdata = '0;
  logic [31:0]     hrdata, rd;
  logic            hreadyout, hresp, sync_done, pe_stall;
  power_state_type power_state = pwr_normal;
  logic            regs_retained = 1'b1, pe_powered_down = 1'b0;
  logic            instr_retired = 1'b0, exception_taken = 1'b0;
  logic            in_prohibited = 1'b0, in_transaction = 1'b0;
  logic            context_sync = 1'b0, trace_sync_barrier_instr = 1'b0;
  logic            stall_en = 1'b0, trace_ready, trace_valid, trace_last;
  logic [7:0]      trace_data;
  logic [3:0]      ext_out;
  int              errors = 0, total_checks = 0, cycles = 0, events, base;

  trace_power_sync_control DUT (
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .power_state,
    .regs_retained, .pe_powered_down, .instr_retired, .exception_taken,
    .in_prohibited, .in_transaction, .context_sync,
    .trace_sync_barrier_instr, .sync_done, .pe_stall, .trace_ready,
    .trace_data, .trace_valid, .trace_last, .ext_out
  );
  trace_buffer_model buffer (
    .clk, .rst, .stall_en, .trace_valid, .trace_last, .trace_ready
  );

  initial begin
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] pdsr_exp(input logic sticky);
    return {30'h0, sticky, 1'b1};
  endfunction

  function automatic logic [31:0] bytes_exp(input int n);
    return 32'(2 * n);
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic pulse(input logic exc, input int count);
    @(posedge clk);
    instr_retired <= !exc;
    exception_taken <= exc;
    @(posedge clk);
    instr_retired <= 1'b0;
    exception_taken <= 1'b0;
    events += count;
  endtask

  task automatic sync_wait();
    int n;
    @(posedge clk);
    trace_sync_barrier_instr <= 1'b1;
    @(posedge clk);
    trace_sync_barrier_instr <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sync_done !== 1'b1 && n < 400);
    chk("sync_done", {31'h0, sync_done}, 32'h1);
  endtask

  task automatic power(input power_state_type s, input logic keep);
    @(posedge clk);
    power_state <= s;
    regs_retained <= keep;
    repeat (3) @(posedge clk);
  endtask

  task automatic bytes_since();
    chk("trace bytes", 32'(buffer.byte_count - base), bytes_exp(events));
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    void'($urandom(1787));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    ahb(1'b0, addr_power_down_status, '0);
    chk("pdsr", rd, pdsr_exp(1'b1));
    ahb(1'b0, addr_power_down_status, '0);
    chk("pdsr", rd, pdsr_exp(1'b0));
    ahb(1'b0, 12'h00C, '0);
    chk("unmapped", rd, 32'h0);
    ahb(1'b1, addr_control, 32'h000000A3);
    ahb(1'b0, addr_control, '0);
    chk("control", rd, 32'h000000A3);
    chk("ext_out", {28'h0, ext_out}, 32'hA);
    for (int t = 0; t < 2; t++) begin
      in_transaction <= t[0];
      stall_en <= t[0];
      events = 0;
      base = buffer.byte_count;
      repeat (4 + $urandom % 9) pulse(1'($urandom % 2), 1);
      context_sync <= 1'b1;
      @(posedge clk);
      context_sync <= 1'b0;
      #1 chk("pe_stall", {31'h0, pe_stall}, 32'h1);
      sync_wait();
      bytes_since();
      chk("packets", 32'(buffer.pkt_count - base / 2), 32'(events));
    end
    stall_en <= 1'b0;
    power(pwr_standby, 1'b1);
    chk("ext_out", {28'h0, ext_out}, 32'h0);
    events = 0;
    base = buffer.byte_count;
    pulse(1'b0, 0);
    ahb(1'b0, addr_control, '0);
    chk("control", rd, 32'h000000A3);
    power(pwr_normal, 1'b1);
    repeat (8) @(posedge clk);
    bytes_since();
    chk("ext_out", {28'h0, ext_out}, 32'hA);
    power(pwr_retention, 1'b1);
    ahb(1'b0, addr_control, '0);
    chk("control", rd, 32'h0);
    power(pwr_normal, 1'b1);
    ahb(1'b0, addr_control, '0);
    chk("control", rd, 32'h000000A3);
    ahb(1'b0, addr_power_down_status, '0);
    chk("pdsr", rd, pdsr_exp(1'b0));
    power(pwr_powerdown, 1'b0);
    power(pwr_normal, 1'b0);
    ahb(1'b0, addr_control, '0);
    chk("control", rd, 32'h0);
    ahb(1'b0, addr_power_down_status, '0);
    chk("pdsr", rd, pdsr_exp(1'b1));
    ahb(1'b1, addr_control, 32'h000000A3);
    pe_powered_down <= 1'b1;
    ahb(1'b0, addr_control, '0);
    chk("control", rd, 32'h0);
    pe_powered_down <= 1'b0;
    ahb(1'b0, addr_power_down_status, '0);
    chk("pdsr", rd, pdsr_exp(1'b1));
    in_prohibited <= 1'b1;
    ahb(1'b1, addr_control, 32'h00000003);
    events = 0;
    base = buffer.byte_count;
    pulse(1'b0, 0);
    pulse(1'b1, 0);
    sync_wait();
    ahb(1'b0, addr_status, '0);
    chk("status", rd, 32'h1 << status_quiesced_bit);
    pulse(1'b0, 0);
    repeat (8) @(posedge clk);
    bytes_since();
    in_prohibited <= 1'b0;
    pulse(1'b0, 1);
    repeat (10) @(posedge clk);
    bytes_since();
    summarize();
  end
endmodule
